//--- logic/acsp_pkg.sv
package acsp_pkg;
  // Core clock period and documented timings, in ns
  localparam int CLK_NS = 5;
  localparam int CONV_NS = 2300;
  localparam int PWRUP_NS = 1500;
  // Least times round up to whole core cycles
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 10;
  // Serial word layout
  localparam int WORD_W = 16;
  localparam int CODE_W = 10;
  localparam int PAD_W = WORD_W - CODE_W;
  localparam int CTRL_W = 12;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] RD_EDGES = 4'hb;
  localparam logic [CNT_W-1:0] WR_EDGES = 4'hd;
  // Synchroniser bit positions and reset value
  localparam int SY_N = 4;
  localparam int SY_CV = 0;
  localparam int SY_RFS = 1;
  localparam int SY_BSY = 2;
  localparam int SY_TGL = 3;
  localparam logic [SY_N-1:0] SY_RST = 4'h1;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  // Converter sequencing states
  typedef enum logic [1:0] {
    ST_DOWN,
    ST_PWRUP,
    ST_IDLE,
    ST_CONV
  } acsp_state_type;
endpackage

//--- logic/acsp_link_if.sv
// Signals between the converter core and the serial link logic
interface acsp_link_if
  import acsp_pkg::*;
();
  logic [WORD_W-1:0] pub_word;
  logic rd_busy;
  logic [CTRL_W-1:0] ctrl_word;
  logic ctrl_tgl;
  modport core (output pub_word, input rd_busy, input ctrl_word, input ctrl_tgl);
  modport link (input pub_word, output rd_busy, output ctrl_word, output ctrl_tgl);
endinterface

//--- logic/acsp_link.sv
module acsp_link
  import acsp_pkg::*;
(
  input wire logic sclk_in, // Shift clock from host
  input wire logic nrst_in, // Async reset, active low
  input wire logic rfs_in, // Read frame sync
  input wire logic tfs_in, // Write frame sync
  input wire logic din_in, // Serial data in
  output logic dout_out, // Serial data out
  output logic dout_oe_out, // Data out enable
  acsp_link_if.link lk // Core side
);
  logic rfs_p_q, tfs_p_q, wen_q, tgl_q;
  logic [CNT_W-1:0] rc_q, wc_q;
  logic [WORD_W-1:0] sh_q;
  logic [CTRL_W-1:0] din_sh_q, ctrl_q;
  logic rstart, wstart;

  // Frame syncs are framed with the shift clock, sampled on its rising edge
  assign rstart = rfs_in & ~rfs_p_q;
  assign wstart = ~tfs_in & tfs_p_q;
  assign lk.rd_busy = dout_oe_out;
  assign lk.ctrl_word = ctrl_q;
  assign lk.ctrl_tgl = tgl_q;

  // Read side: drive one bit per rising edge, release on the 11th
  always_ff @(posedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rfs_p_q <= 1'b0;
      rc_q <= '0;
      sh_q <= WORD_RST;
      dout_out <= 1'b0;
      dout_oe_out <= 1'b0;
    end else begin
      rfs_p_q <= rfs_in;
      if (rstart) begin // see R14 see R15 see R19
        sh_q <= {lk.pub_word[WORD_W-2:0], 1'b0}; // see R22
        dout_out <= lk.pub_word[WORD_W-1]; // see R16
        dout_oe_out <= 1'b1;
        rc_q <= 4'h1;
      end else if (rc_q == RD_EDGES - 4'h1) begin
        dout_oe_out <= 1'b0; // see R16 see R23
        rc_q <= RD_EDGES; // see R15
      end else if (rc_q != 4'h0 && rc_q != RD_EDGES) begin
        dout_out <= sh_q[WORD_W-1]; // see R20
        sh_q <= {sh_q[WORD_W-2:0], 1'b0};
        rc_q <= rc_q + 4'h1;
      end
    end
  end

  // Write side: count rising edges, load control on the 13th
  always_ff @(posedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tfs_p_q <= 1'b1;
      wc_q <= '0;
      wen_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      tgl_q <= 1'b0;
    end else begin
      tfs_p_q <= tfs_in;
      if (wstart) begin // see R15 see R19
        wc_q <= 4'h1;
        wen_q <= 1'b1;
      end else if (wen_q && wc_q == WR_EDGES - 4'h1) begin
        ctrl_q <= din_sh_q; // see R18
        tgl_q <= ~tgl_q;
        wen_q <= 1'b0;
        wc_q <= WR_EDGES;
      end else if (wen_q) begin
        wc_q <= wc_q + 4'h1;
      end
    end
  end

  // Input bits are taken on falling edges while a write is framed
  always_ff @(negedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      din_sh_q <= CTRL_RST;
    end else if (wen_q) begin
      din_sh_q <= {din_sh_q[CTRL_W-2:0], din_in}; // see R17
    end
  end

  default clocking cb @(posedge sclk_in); endclocking
  default disable iff (!nrst_in);

  property p_rd_release;
    (rc_q == RD_EDGES - 4'h1) && !rstart |=> !dout_oe_out && rc_q == RD_EDGES;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("read not released"); // see R16

  property p_rd_start;
    rstart |=> dout_oe_out && dout_out == $past(lk.pub_word[WORD_W-1]);
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start wrong"); // see R14

  property p_wr_load;
    wen_q && wc_q == WR_EDGES - 4'h1 && !wstart |=> tgl_q != $past(tgl_q);
  endproperty
  a_wr_load: assert property (p_wr_load) else $error("control not loaded"); // see R18

  property p_idle_quiet;
    rc_q == RD_EDGES && !rstart |=> !dout_oe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output while idle"); // see R19
endmodule

//--- logic/acsp_core.sv
// Notes on behaviour
// R1 - Strobe falling edge holds the sample and starts a conversion.
// R2 - Conversion ends after 2.3 us, latching result and sampling strobe.
// R3 - Strobe high at conversion end keeps the converter powered.
// R4 - Strobe low at conversion end powers the converter down.
// R5 - Strobe rising while powered down starts a 1.5 us power-up.
// R6 - Early strobe fall waits out power-up, then converts.
// R7 - Read begun before conversion end returns previous result.
// R8 - New result waits for a running read to finish.
// R9 - Read begun after conversion end returns the new result.
// R10 - Host may read any time after the strobe rises.
// R11 - Host ends reads 100 ns before the next strobe fall.
// R12 - Host waits 2.3 us after power-up or strobe fall to read.
// R13 - Serial port works while the converter is powered down.
// R14 - Port enables on first rising shift edge after read sync rises.
// R15 - Sync edges clear the bit counter; extra clocks are ignored.
// R16 - Output drives from first rising edge, releases on the 11th.
// R17 - Input bits taken on falling edges after write sync falls.
// R18 - Control word updates on the 13th rising edge of a write.
// R19 - Nothing shifts until an active frame sync edge arrives.
// R20 - Works with free-running or gated shift clock.
// R21 - Three-wire use only with a gated shift clock.
// R22 - Result goes out MSB first, left-justified in 16 bits.
// R23 - Data output stays released whenever no read is active.
module acsp_core
  import acsp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC, // Conversion length in cycles
  parameter int PWRUP_CYCLES = PWRUP_CYC // Power-up length in cycles
) (
  input wire logic clock_in, // Core clock, 200 MHz
  input wire logic nrst_in, // Async reset, active low
  input wire logic sclk_in, // Serial shift clock
  input wire logic sample_convert_strobe_n_in, // Convert strobe, active low
  input wire logic read_frame_sync_in, // Read frame sync
  input wire logic write_frame_sync_in, // Write frame sync
  input wire logic din_in, // Serial data in
  input wire logic [CODE_W-1:0] adc_code_in, // Code from the converter array
  output logic dout_out, // Serial data out
  output logic dout_oe_out, // Serial data out enable
  output logic powered_out, // Converter powered
  output logic hold_out, // Sample held, conversion running
  output logic [CTRL_W-1:0] ctrl_word_out // Last control word written
);

  // Counts that cannot fit the timer are refused
  if (CONV_CYCLES < 1 || CONV_CYCLES >= 2 ** TMR_W) begin : g_conv_chk
    $error("conversion count out of range");
  end
  if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= 2 ** TMR_W) begin : g_pwr_chk
    $error("power-up count out of range");
  end

  localparam logic [TMR_W-1:0] CONV_LOAD = TMR_W'(CONV_CYCLES - 1);
  localparam logic [TMR_W-1:0] PWR_LOAD = TMR_W'(PWRUP_CYCLES - 1);

  acsp_link_if lnk ();

  // Serial port logic on the shift clock, alive in every power state
  acsp_link u_link ( // see R13
    .sclk_in (sclk_in),
    .nrst_in (nrst_in),
    .rfs_in (read_frame_sync_in),
    .tfs_in (write_frame_sync_in),
    .din_in (din_in),
    .dout_out (dout_out),
    .dout_oe_out (dout_oe_out),
    .lk (lnk.link)
  );

  // Input synchronisers, three stages, accepted when stages two and three agree
  logic [SY_N-1:0] sy1_q, sy2_q, sy3_q, syf_q, syp_q;
  logic [SY_N-1:0] sy_raw;

  assign sy_raw[SY_CV] = sample_convert_strobe_n_in;
  assign sy_raw[SY_RFS] = read_frame_sync_in;
  assign sy_raw[SY_BSY] = lnk.rd_busy;
  assign sy_raw[SY_TGL] = lnk.ctrl_tgl;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sy1_q <= SY_RST;
      sy2_q <= SY_RST;
      sy3_q <= SY_RST;
    end else begin
      sy1_q <= sy_raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // Filtered levels and their previous values for edge detection
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      syf_q <= SY_RST;
      syp_q <= SY_RST;
    end else begin
      for (int i = 0; i < SY_N; i++) begin
        if (sy2_q[i] == sy3_q[i]) begin
          syf_q[i] <= sy2_q[i];
        end
      end
      syp_q <= syf_q;
    end
  end

  // Edge and level terms for the sequencer, the result publish and the control hand-over
  logic cv_lvl, cv_rise, cv_fall, rd_hold, tgl_chg;

  assign cv_lvl = syf_q[SY_CV];
  assign cv_rise = syf_q[SY_CV] & ~syp_q[SY_CV];
  assign cv_fall = ~syf_q[SY_CV] & syp_q[SY_CV];
  assign rd_hold = syf_q[SY_RFS] | syf_q[SY_BSY];
  assign tgl_chg = syf_q[SY_TGL] ^ syp_q[SY_TGL];

  // Sequencer state
  acsp_state_type st_q, st_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic fp_q, fp_d;
  logic conv_end;

  assign conv_end = (st_q == ST_CONV) && (tmr_q == '0);

  // Next-state logic for power-up and conversion sequencing
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    fp_d = fp_q;
    unique case (st_q)
      ST_DOWN: begin
        if (cv_rise) begin
          st_d = ST_PWRUP; // see R5
          tmr_d = PWR_LOAD;
          fp_d = 1'b0;
        end
      end
      ST_PWRUP: begin
        if (cv_fall) begin
          fp_d = 1'b1; // see R6
        end
        if (tmr_q == '0) begin
          if (fp_q || cv_fall) begin
            st_d = ST_CONV; // see R6
            tmr_d = CONV_LOAD;
          end else begin
            st_d = ST_IDLE;
          end
          fp_d = 1'b0;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      ST_IDLE: begin
        if (cv_fall) begin
          st_d = ST_CONV; // see R1
          tmr_d = CONV_LOAD;
        end
      end
      ST_CONV: begin
        if (tmr_q == '0) begin
          st_d = cv_lvl ? ST_IDLE : ST_DOWN; // see R2 see R3 see R4
        end else begin
          tmr_d = tmr_q - 1'b1; // see R2
        end
      end
    endcase
  end

  // Sequencer registers and the power and hold outputs
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ST_DOWN;
      tmr_q <= '0;
      fp_q <= 1'b0;
      powered_out <= 1'b0;
      hold_out <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      fp_q <= fp_d;
      powered_out <= (st_d != ST_DOWN); // see R4
      hold_out <= (st_d == ST_CONV); // see R1
    end
  end

  // Result latch and deferred publish towards the shift register
  logic [CODE_W-1:0] code_q;
  logic pend_q;
  logic [WORD_W-1:0] pub_q;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      code_q <= '0;
      pend_q <= 1'b0;
    end else if (conv_end) begin
      code_q <= adc_code_in; // see R2
      pend_q <= 1'b1;
    end else if (pend_q && !rd_hold) begin
      pend_q <= 1'b0;
    end
  end

  // A framed or running read keeps the old word in place
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pub_q <= WORD_RST;
    end else if (pend_q && !rd_hold) begin
      pub_q <= {code_q, {PAD_W{1'b0}}}; // see R8 see R9 see R22
    end
  end

  assign lnk.pub_word = pub_q; // see R7

  // Control word taken over once the write toggle settles
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_word_out <= CTRL_RST;
    end else if (tgl_chg) begin
      ctrl_word_out <= lnk.ctrl_word; // see R18
    end
  end

  // Helper counters for checking cycle figures
  logic [TMR_W-1:0] hc_q, pc_q;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hc_q <= '0;
      pc_q <= '0;
    end else begin
      hc_q <= hold_out ? hc_q + 1'b1 : '0;
      if (st_q == ST_PWRUP) begin
        pc_q <= pc_q + 1'b1;
      end else if (st_q == ST_DOWN) begin
        pc_q <= '0;
      end
    end
  end

  default clocking cc @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence s_idle_fall;
    st_q == ST_IDLE && cv_fall;
  endsequence

  sequence s_conv_run;
    hold_out && st_q == ST_CONV;
  endsequence

  property p_conv_start;
    s_idle_fall |=> s_conv_run;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("no conversion on fall"); // see R1

  property p_conv_len;
    $fell(hold_out) |-> hc_q == TMR_W'(CONV_CYCLES);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // see R2

  property p_stay_up;
    conv_end && cv_lvl |=> st_q == ST_IDLE ##1 powered_out;
  endproperty
  a_stay_up: assert property (p_stay_up) else $error("powered down in fast mode"); // see R3

  property p_auto_down;
    conv_end && !cv_lvl |=> st_q == ST_DOWN && pend_q ##1 !powered_out;
  endproperty
  a_auto_down: assert property (p_auto_down) else $error("no automatic power-down"); // see R4

  property p_wake;
    st_q == ST_DOWN && cv_rise |=> st_q == ST_PWRUP ##1 powered_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no power-up on rising strobe"); // see R5

  property p_pwrup_full;
    $rose(hold_out) && $past(st_q) == ST_PWRUP |-> pc_q == TMR_W'(PWRUP_CYCLES);
  endproperty
  a_pwrup_full: assert property (p_pwrup_full) else $error("power-up cut short"); // see R6

  property p_defer;
    rd_hold && !conv_end |=> $stable(pub_q);
  endproperty
  a_defer: assert property (p_defer) else $error("word changed during read"); // see R8

  sequence s_ready_pub;
    pend_q && !rd_hold && !conv_end;
  endsequence

  property p_publish;
    s_ready_pub |=> pub_q == {$past(code_q), {PAD_W{1'b0}}} && !pend_q;
  endproperty
  a_publish: assert property (p_publish) else $error("new result not published"); // see R9

  property p_down_quiet;
    st_q == ST_DOWN && !cv_rise |=> !hold_out;
  endproperty
  a_down_quiet: assert property (p_down_quiet) else $error("hold while powered down"); // see R4

  // Single-step checks of the sequencer, result latch and control hand-over
  property p_latch;
    conv_end |=> code_q == $past(adc_code_in) && pend_q;
  endproperty
  a_latch: assert property (p_latch) else $error("result not latched"); // see R2

  property p_conv_busy;
    st_q == ST_CONV && tmr_q != '0 |=> st_q == ST_CONV && hold_out;
  endproperty
  a_conv_busy: assert property (p_conv_busy) else $error("conversion cut short"); // see R1

  property p_idle_stay;
    st_q == ST_IDLE && !cv_fall |=> st_q == ST_IDLE && powered_out;
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("idle state left"); // see R3

  property p_early_fall;
    st_q == ST_PWRUP && cv_fall && tmr_q != '0 |=> st_q == ST_PWRUP && fp_q;
  endproperty
  a_early_fall: assert property (p_early_fall) else $error("early fall lost"); // see R6

  property p_pwrup_idle;
    st_q == ST_PWRUP && tmr_q == '0 && !fp_q && !cv_fall |=> st_q == ST_IDLE && !hold_out;
  endproperty
  a_pwrup_idle: assert property (p_pwrup_idle) else $error("power-up end wrong"); // see R6

  property p_down_stay;
    st_q == ST_DOWN && !cv_rise |=> st_q == ST_DOWN && !powered_out;
  endproperty
  a_down_stay: assert property (p_down_stay) else $error("woke without rise"); // see R5

  property p_pend_keep;
    pend_q && rd_hold && !conv_end |=> pend_q;
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("pending result dropped"); // see R8

  property p_old_word;
    !pend_q |=> $stable(pub_q);
  endproperty
  a_old_word: assert property (p_old_word) else $error("word changed with nothing pending"); // see R7

  property p_ctrl_take;
    tgl_chg |=> ctrl_word_out == $past(lnk.ctrl_word);
  endproperty
  a_ctrl_take: assert property (p_ctrl_take) else $error("control word not taken"); // see R18
endmodule

//--- tb/acsp_host.sv
// Host serial port: gated shift clock, frame syncs, data in, data out sampling
module acsp_host (
  output logic sclk_out, // Shift clock, low and still between host tasks
  output logic rfs_out, // Read frame sync
  output logic tfs_out, // Write frame sync
  output logic din_out, // Serial data to the device
  input wire logic dout_in, // Serial data from the device
  input wire logic dout_oe_in // Device drives its data pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels: clock low, read sync low, write sync high
  initial begin
    sclk_out = 1'b0;
    rfs_out = 1'b0;
    tfs_out = 1'b1;
    din_out = 1'b0;
  end
  // One clock pulse of 48 ns
  task automatic pulse();
    #24 sclk_out = 1'b1;
    #24 sclk_out = 1'b0;
  endtask
  // Clocks with both syncs idle; reports whether the pin was ever driven
  task automatic free_clocks(input int n, output logic oe_seen);
    oe_seen = 1'b0;
    repeat (n) begin
      pulse();
      if (dout_oe_in !== 1'b0) oe_seen = 1'b1;
    end
  endtask
  // Read frame: one edge with sync low, then 11 rising edges
  task automatic read_word(output logic [15:0] w, output logic oe_ok);
    w = 16'h0000;
    oe_ok = 1'b1;
    rfs_out = 1'b0;
    pulse();
    rfs_out = 1'b1;
    #24;
    for (int k = 0; k < 11; k++) begin
      sclk_out = 1'b1;
      #2;
      if (k < 10) begin
        w[15-k] = dout_in;
        if (dout_oe_in !== 1'b1) oe_ok = 1'b0;
      end else if (dout_oe_in !== 1'b0) begin
        oe_ok = 1'b0;
      end
      #22 sclk_out = 1'b0;
      #24;
    end
    rfs_out = 1'b0;
  endtask
  // Write frame: sync falls while the clock is low, MSB first, n rising edges
  task automatic write_word(input logic [15:0] d, input int n);
    tfs_out = 1'b1;
    pulse();
    tfs_out = 1'b0;
    for (int k = 0; k < n; k++) begin
      // Data moves while the clock is high, away from the capturing fall
      #24 sclk_out = 1'b1;
      #12 din_out = (k < 16) ? d[15-k] : 1'b0;
      #12 sclk_out = 1'b0;
    end
    tfs_out = 1'b1;
    din_out = ~din_out;
  endtask
endmodule

//--- tb/acsp_core_test.sv
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module acsp_core_test;
  import acsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV_T = 20;
  localparam int PWRUP_T = 10;
  logic clock_in, nrst_in, strobe_n, sclk, read_frame_sync, write_frame_sync, din;
  logic [CODE_W-1:0] code;
  logic dout, dout_oe, powered, hold;
  logic [CTRL_W-1:0] ctrl;
  int err_total = 0;
  int tests_run = 0;
  acsp_core #(.CONV_CYCLES(CONV_T), .PWRUP_CYCLES(PWRUP_T)) u_acsp_core (
    .clock_in(clock_in), .nrst_in(nrst_in), .sclk_in(sclk),
    .sample_convert_strobe_n_in(strobe_n), .read_frame_sync_in(read_frame_sync),
    .write_frame_sync_in(write_frame_sync), .din_in(din), .adc_code_in(code),
    .dout_out(dout), .dout_oe_out(dout_oe), .powered_out(powered),
    .hold_out(hold), .ctrl_word_out(ctrl));
  acsp_host u_acsp_host (.sclk_out(sclk), .rfs_out(read_frame_sync), .tfs_out(write_frame_sync), .din_out(din),
    .dout_in(dout), .dout_oe_in(dout_oe));
  // Core clock, 5 ns
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Bounded wait for the conversion flag; n counts cycles waited
  task automatic wait_hold(input logic v, output int n);
    n = 0;
    while (hold !== v) begin
      @(negedge clock_in);
      n++;
      if (n > 2000) begin
        err_total++;
        $display("mismatch hold_wait expected %h seen %h", v, hold);
        end_of_test();
      end
    end
  endtask
  // Read a word and check it with the pin enable framing
  task automatic read_chk(input string nm, input logic [CODE_W-1:0] c);
    logic [15:0] w;
    logic ok;
    u_acsp_host.read_word(w, ok);
    `CHK(nm, {c, 6'h00}, w)
    `CHK("read_oe", 1'b1, ok)
  endtask
  task automatic t_reset();
    logic seen;
    `CHK("oe_rst", 1'b0, dout_oe)
    `CHK("pwr_rst", 1'b0, powered)
    `CHK("hold_rst", 1'b0, hold)
    `CHK("ctrl_rst", 12'h000, ctrl)
    u_acsp_host.free_clocks(6, seen);
    `CHK("idle_oe", 1'b0, seen)
    $display("test reset done");
  endtask
  task automatic t_powerup();
    int n;
    @(negedge clock_in) code = 10'h2a5;
    strobe_n = 1'b0;
    repeat (10) @(negedge clock_in);
    strobe_n = 1'b1;
    n = 0;
    while (powered !== 1'b1 && n < 20) begin
      @(negedge clock_in);
      n++;
    end
    `CHK("pwrup_start", 1'b1, n <= 6)
    if (n >= 20) end_of_test();
    repeat (2) @(negedge clock_in);
    strobe_n = 1'b0;
    wait_hold(1'b1, n);
    `CHK("pwrup_wait", 1'b1, n >= PWRUP_T - 2 && n <= PWRUP_T + 3)
    strobe_n = 1'b1;
    wait_hold(1'b0, n);
    `CHK("conv_len", CONV_T, n)
    repeat (3) @(negedge clock_in);
    `CHK("mode1_pwr", 1'b1, powered)
    read_chk("first_result", 10'h2a5);
    $display("test powerup done");
  endtask
  task automatic t_overlap();
    int n;
    logic [15:0] w;
    logic ok;
    repeat (20) @(negedge clock_in);
    @(negedge clock_in) code = 10'h15a;
    strobe_n = 1'b0;
    fork
      u_acsp_host.read_word(w, ok);
      begin
        wait_hold(1'b1, n);
        @(negedge clock_in) strobe_n = 1'b1;
        wait_hold(1'b0, n);
      end
    join
    `CHK("read_prev", {10'h2a5, 6'h00}, w)
    `CHK("prev_oe", 1'b1, ok)
    repeat (40) @(negedge clock_in);
    read_chk("read_new", 10'h15a);
    $display("test overlap done");
  endtask
  task automatic t_mode2();
    int n;
    repeat (20) @(negedge clock_in);
    @(negedge clock_in) code = 10'h0c3;
    strobe_n = 1'b0;
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
    repeat (3) @(negedge clock_in);
    `CHK("mode2_pwr", 1'b0, powered)
    read_chk("down_read", 10'h0c3);
    @(negedge clock_in) strobe_n = 1'b1;
    $display("test mode2 done");
  endtask
  task automatic t_write();
    u_acsp_host.write_word(16'ha5c3, 16);
    repeat (20) @(negedge clock_in);
    `CHK("ctrl_long", 12'ha5c, ctrl)
    u_acsp_host.write_word(16'h3c60, 13);
    repeat (20) @(negedge clock_in);
    `CHK("ctrl_min", 12'h3c6, ctrl)
    $display("test write done");
  endtask
  // Main sequence
  initial begin
    nrst_in = 1'b0;
    strobe_n = 1'b1;
    code = 10'h000;
    repeat (2) @(posedge clock_in);
    @(negedge clock_in) nrst_in = 1'b1;
    repeat (6) @(negedge clock_in);
    t_reset();
    t_powerup();
    t_overlap();
    t_mode2();
    t_write();
    end_of_test();
  end
endmodule
